// ### rtl/dcr_pkg.sv
// Constants, types and encodings of the drive command register bank
package dcr_pkg;

    // ==========================================================
    // Register indices (function code numbers)
    localparam logic [7:0] IDX_FREQ_SCALED = 8'h01;
    localparam logic [7:0] IDX_FREQ_HZ = 8'h05;
    localparam logic [7:0] IDX_RUN_WORD = 8'h06;
    localparam logic [7:0] IDX_PID_MAIN = 8'h0d;
    localparam logic [7:0] IDX_FAULT_CLEAR = 8'h0e;
    localparam logic [7:0] IDX_SPEED_RPM = 8'h13;
    localparam logic [7:0] IDX_EXT_PID_ONE = 8'h1f;
    localparam logic [7:0] IDX_EXT_PID_TWO = 8'h20;
    localparam logic [7:0] IDX_EXT_PID_THREE = 8'h21;
    localparam logic [7:0] IDX_CLK_YEAR_MONTH = 8'h5a;
    localparam logic [7:0] IDX_CLK_DAY_HOUR = 8'h5b;
    localparam logic [7:0] IDX_CLK_MIN_SEC = 8'h5c;
    localparam logic [7:0] IDX_CLK_COMMIT = 8'h5d;

    // ==========================================================
    // Reset values, fields and scales
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [15:0] COMMIT_WRITE = 16'h0001;
    localparam logic [15:0] FAULT_CLEAR_WRITE = 16'h0001;
    localparam logic [16:0] FREQ_FULL_SCALE = 17'd20000;
    localparam int RUN_BIT_FWD = 0;
    localparam int RUN_BIT_REV = 1;
    localparam int RUN_BIT_GP_LO = 2;
    localparam int RUN_BIT_XF = 13;
    localparam int RUN_BIT_XR = 14;
    localparam int RUN_BIT_ALARM = 15;
    localparam logic [1:0] PID_MODE_PROCESS_A = 2'd1;
    localparam logic [1:0] PID_MODE_PROCESS_B = 2'd2;

    // ==========================================================
    // Timing
    localparam int CLK_FREQ_MHZ = 100;
    localparam int RESET_PULSE_MS = 10;
    localparam int RESET_PULSE_CYCLES = RESET_PULSE_MS * 1000 * CLK_FREQ_MHZ;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_SPEED = 2'b01,
        SRC_HZ = 2'b11,
        SRC_SCALED = 2'b10
    } dcr_src_type;

    typedef enum logic [0:0] {
        PULSE_IDLE = 1'b0,
        PULSE_ACTIVE = 1'b1
    } dcr_pulse_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] idx;
        logic [15:0] wdata;
    } dcr_req_type;

    typedef struct packed {
        logic [15:0] year_month;
        logic [15:0] day_hour;
        logic [15:0] min_sec;
    } dcr_time_type;

endpackage : dcr_pkg

// ### rtl/dcr_command_bank.sv
// Drive command register bank: command words, set-point selection and alarm reset
`timescale 1ns/1ps
module dcr_command_bank
    import dcr_pkg::*;
#(
    parameter int PULSE_CYCLES = RESET_PULSE_CYCLES
) (
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    input wire dcr_req_type REQ_IN,
    input wire logic [16:0] FREQ_UPPER_LIMIT_IN,
    input wire logic [1:0] PID_MODE_IN,
    input wire logic LINK_SEL_OK_IN,
    input wire logic LINK_ENABLE_TERMINAL_IN,
    output logic [15:0] RDATA_OUT,
    output logic RVALID_OUT,
    output dcr_src_type FREQ_SOURCE_OUT,
    output logic [15:0] FREQ_SCALED_OUT,
    output logic [15:0] FREQ_HZ_OUT,
    output logic [15:0] SPEED_RPM_OUT,
    output logic [15:0] PID_MAIN_OUT,
    output logic [47:0] EXT_PID_OUT,
    output logic RUN_FORWARD_OUT,
    output logic RUN_REVERSE_OUT,
    output logic [8:0] GENERAL_INPUTS_OUT,
    output logic LINK_ENABLED_OUT,
    output dcr_time_type CLOCK_TIME_OUT,
    output logic CLOCK_LOAD_OUT,
    output logic ALARM_RESET_OUT
);

    // ==========================================================
    // Helpers
    function automatic logic is_write(input dcr_req_type req, input logic [7:0] idx);
        is_write = req.wr && (req.idx == idx);
    endfunction : is_write

    function automatic logic [16:0] mag17(input logic [15:0] v);
        mag17 = v[15] ? (17'h00000 - {v[15], v}) : {1'b0, v};
    endfunction : mag17

    // ==========================================================
    // Command word storage
    logic [15:0] freq_scaled_r;
    logic [15:0] freq_hz_r;
    logic [15:0] run_word_r;
    logic [15:0] pid_main_r;
    logic [15:0] speed_rpm_r;
    logic [15:0] ext_pid_one_r;
    logic [15:0] ext_pid_two_r;
    logic [15:0] ext_pid_three_r;
    logic [15:0] clk_ym_r;
    logic [15:0] clk_dh_r;
    logic [15:0] clk_ms_r;
    logic [15:0] commit_r;
    logic scaled_written_r;
    logic hz_written_r;
    logic speed_written_r;

    // Any value is stored; limiting happens only on the applied path
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            freq_scaled_r <= WORD_RESET;
            freq_hz_r <= WORD_RESET;
            pid_main_r <= WORD_RESET;
            speed_rpm_r <= WORD_RESET;
            ext_pid_one_r <= WORD_RESET;
            ext_pid_two_r <= WORD_RESET;
            ext_pid_three_r <= WORD_RESET;
            run_word_r <= WORD_RESET;
        end else begin
            if (is_write(REQ_IN, IDX_FREQ_SCALED)) freq_scaled_r <= REQ_IN.wdata;
            if (is_write(REQ_IN, IDX_FREQ_HZ)) freq_hz_r <= REQ_IN.wdata;
            if (is_write(REQ_IN, IDX_PID_MAIN)) pid_main_r <= REQ_IN.wdata;
            if (is_write(REQ_IN, IDX_SPEED_RPM)) speed_rpm_r <= REQ_IN.wdata;
            if (is_write(REQ_IN, IDX_EXT_PID_ONE)) ext_pid_one_r <= REQ_IN.wdata;
            if (is_write(REQ_IN, IDX_EXT_PID_TWO)) ext_pid_two_r <= REQ_IN.wdata;
            if (is_write(REQ_IN, IDX_EXT_PID_THREE)) ext_pid_three_r <= REQ_IN.wdata;
            if (is_write(REQ_IN, IDX_RUN_WORD)) run_word_r <= REQ_IN.wdata;
        end
    end

    // A word counts as specified once written after reset
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            scaled_written_r <= 1'b0;
            hz_written_r <= 1'b0;
            speed_written_r <= 1'b0;
        end else begin
            if (is_write(REQ_IN, IDX_FREQ_SCALED)) scaled_written_r <= 1'b1;
            if (is_write(REQ_IN, IDX_FREQ_HZ)) hz_written_r <= 1'b1;
            if (is_write(REQ_IN, IDX_SPEED_RPM)) speed_written_r <= 1'b1;
        end
    end

    // ==========================================================
    // Clock set words and self-clearing commit
    logic commit_fire;
    assign commit_fire = (commit_r == COMMIT_WRITE);

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            clk_ym_r <= WORD_RESET;
            clk_dh_r <= WORD_RESET;
            clk_ms_r <= WORD_RESET;
        end else begin
            if (is_write(REQ_IN, IDX_CLK_YEAR_MONTH)) clk_ym_r <= REQ_IN.wdata;
            if (is_write(REQ_IN, IDX_CLK_DAY_HOUR)) clk_dh_r <= REQ_IN.wdata;
            if (is_write(REQ_IN, IDX_CLK_MIN_SEC)) clk_ms_r <= REQ_IN.wdata;
        end
    end

    // A new write beats the automatic clear in the same cycle
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            commit_r <= WORD_RESET;
        end else if (is_write(REQ_IN, IDX_CLK_COMMIT)) begin
            commit_r <= REQ_IN.wdata;
        end else if (commit_fire) begin
            commit_r <= WORD_RESET;
        end
    end

    // Time is frozen into the output register with the load strobe
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            CLOCK_TIME_OUT <= '0;
            CLOCK_LOAD_OUT <= 1'b0;
        end else begin
            CLOCK_LOAD_OUT <= commit_fire;
            if (commit_fire) begin
                CLOCK_TIME_OUT <= '{year_month: clk_ym_r, day_hour: clk_dh_r, min_sec: clk_ms_r};
            end
        end
    end

    // ==========================================================
    // Register read port
    logic [15:0] rdata_nxt;

    always_comb begin
        unique case (REQ_IN.idx)
            IDX_FREQ_SCALED: rdata_nxt = freq_scaled_r;
            IDX_FREQ_HZ: rdata_nxt = freq_hz_r;
            IDX_RUN_WORD: rdata_nxt = run_word_r;
            IDX_PID_MAIN: rdata_nxt = pid_main_r;
            IDX_FAULT_CLEAR: rdata_nxt = WORD_RESET;
            IDX_SPEED_RPM: rdata_nxt = speed_rpm_r;
            IDX_EXT_PID_ONE: rdata_nxt = ext_pid_one_r;
            IDX_EXT_PID_TWO: rdata_nxt = ext_pid_two_r;
            IDX_EXT_PID_THREE: rdata_nxt = ext_pid_three_r;
            IDX_CLK_YEAR_MONTH: rdata_nxt = clk_ym_r;
            IDX_CLK_DAY_HOUR: rdata_nxt = clk_dh_r;
            IDX_CLK_MIN_SEC: rdata_nxt = clk_ms_r;
            IDX_CLK_COMMIT: rdata_nxt = commit_r;
            default: rdata_nxt = WORD_RESET;
        endcase
    end

    // Stored words, never the applied values
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            RDATA_OUT <= WORD_RESET;
            RVALID_OUT <= 1'b0;
        end else begin
            RVALID_OUT <= REQ_IN.rd;
            if (REQ_IN.rd) RDATA_OUT <= rdata_nxt;
        end
    end

    // ==========================================================
    // Frequency source precedence and limiting
    dcr_src_type src_nxt;
    logic [16:0] limit_mag;
    logic [16:0] scaled_mag;
    logic [16:0] clip_mag;
    logic [15:0] scaled_nxt;

    always_comb begin
        if (scaled_written_r && freq_scaled_r != WORD_RESET) begin
            src_nxt = SRC_SCALED;
        end else if (hz_written_r && (freq_hz_r != WORD_RESET || !speed_written_r)) begin
            src_nxt = SRC_HZ;
        end else if (speed_written_r) begin
            src_nxt = SRC_SPEED;
        end else if (scaled_written_r) begin
            src_nxt = SRC_SCALED;
        end else begin
            src_nxt = SRC_NONE;
        end
    end

    // Lower of full scale and the configured upper limit
    always_comb begin
        limit_mag = (FREQ_UPPER_LIMIT_IN < FREQ_FULL_SCALE) ? FREQ_UPPER_LIMIT_IN : FREQ_FULL_SCALE;
        scaled_mag = mag17(freq_scaled_r);
        clip_mag = (scaled_mag > limit_mag) ? limit_mag : scaled_mag;
        scaled_nxt = freq_scaled_r[15] ? 16'(17'h00000 - clip_mag) : clip_mag[15:0];
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            FREQ_SOURCE_OUT <= SRC_NONE;
            FREQ_SCALED_OUT <= WORD_RESET;
            FREQ_HZ_OUT <= WORD_RESET;
            SPEED_RPM_OUT <= WORD_RESET;
        end else begin
            FREQ_SOURCE_OUT <= src_nxt;
            FREQ_SCALED_OUT <= scaled_nxt;
            FREQ_HZ_OUT <= freq_hz_r;
            SPEED_RPM_OUT <= speed_rpm_r;
        end
    end

    // ==========================================================
    // PID set-points
    logic pid_process;
    assign pid_process = (PID_MODE_IN == PID_MODE_PROCESS_A) || (PID_MODE_IN == PID_MODE_PROCESS_B);

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            PID_MAIN_OUT <= WORD_RESET;
            EXT_PID_OUT <= '0;
        end else begin
            PID_MAIN_OUT <= (pid_process && pid_main_r[15]) ? WORD_RESET : pid_main_r;
            EXT_PID_OUT <= {ext_pid_three_r, ext_pid_two_r, ext_pid_one_r};
        end
    end

    // ==========================================================
    // Link enable terminal, three-stage with agreement filter
    logic [2:0] le_sync_r;
    logic le_stable_r;
    logic link_en_r;

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            le_sync_r <= 3'h0;
        end else begin
            le_sync_r <= {le_sync_r[1:0], LINK_ENABLE_TERMINAL_IN};
        end
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            le_stable_r <= 1'b0;
        end else if (le_sync_r[1] == le_sync_r[2]) begin
            le_stable_r <= le_sync_r[2];
        end
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            link_en_r <= 1'b0;
        end else begin
            link_en_r <= le_stable_r && LINK_SEL_OK_IN;
        end
    end

    // ==========================================================
    // Operation word outputs, always positive logic
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            RUN_FORWARD_OUT <= 1'b0;
            RUN_REVERSE_OUT <= 1'b0;
            GENERAL_INPUTS_OUT <= 9'h000;
            LINK_ENABLED_OUT <= 1'b0;
        end else begin
            RUN_FORWARD_OUT <= run_word_r[RUN_BIT_FWD];
            RUN_REVERSE_OUT <= run_word_r[RUN_BIT_REV];
            // Function mapping of these bits belongs to the input assignment logic
            GENERAL_INPUTS_OUT <= {run_word_r[RUN_BIT_XR], run_word_r[RUN_BIT_XF],
                run_word_r[RUN_BIT_GP_LO+6:RUN_BIT_GP_LO]};
            LINK_ENABLED_OUT <= link_en_r;
        end
    end

    // ==========================================================
    // Alarm reset: word bit 15 release or pulse word write
    logic alarm_bit_prev_r;
    logic word_reset_trig;
    logic pulse_reset_trig;
    dcr_pulse_type pulse_r;
    dcr_pulse_type pulse_nxt;
    logic [31:0] pulse_cnt_r;
    logic [31:0] pulse_cnt_nxt;

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            alarm_bit_prev_r <= 1'b0;
        end else begin
            alarm_bit_prev_r <= run_word_r[RUN_BIT_ALARM];
        end
    end

    // Acting on the release avoids a reset held for as long as the bit stays set
    assign word_reset_trig = alarm_bit_prev_r && !run_word_r[RUN_BIT_ALARM] && link_en_r;
    assign pulse_reset_trig = is_write(REQ_IN, IDX_FAULT_CLEAR) && REQ_IN.wdata == FAULT_CLEAR_WRITE;

    // A new trigger restarts the full period
    always_comb begin
        pulse_nxt = pulse_r;
        pulse_cnt_nxt = pulse_cnt_r;
        unique case (pulse_r)
            PULSE_IDLE: begin
                if (word_reset_trig || pulse_reset_trig) begin
                    pulse_nxt = PULSE_ACTIVE;
                    pulse_cnt_nxt = 32'h00000000;
                end
            end
            PULSE_ACTIVE: begin
                if (word_reset_trig || pulse_reset_trig) begin
                    pulse_cnt_nxt = 32'h00000000;
                end else if (pulse_cnt_r >= 32'(PULSE_CYCLES - 1)) begin
                    pulse_nxt = PULSE_IDLE;
                end else begin
                    pulse_cnt_nxt = pulse_cnt_r + 32'h00000001;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            pulse_r <= PULSE_IDLE;
            pulse_cnt_r <= 32'h00000000;
            ALARM_RESET_OUT <= 1'b0;
        end else begin
            pulse_r <= pulse_nxt;
            pulse_cnt_r <= pulse_cnt_nxt;
            ALARM_RESET_OUT <= (pulse_nxt == PULSE_ACTIVE);
        end
    end

    // ==========================================================
    // Checks
    chk_scaled_precedence: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        (scaled_written_r && freq_scaled_r != 16'h0000) |=> FREQ_SOURCE_OUT == SRC_SCALED)
        else $error("Nonzero scaled word did not take precedence");

    chk_hz_precedence: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        (hz_written_r && speed_written_r && freq_hz_r != 16'h0000 &&
         (!scaled_written_r || freq_scaled_r == 16'h0000)) |=> FREQ_SOURCE_OUT == SRC_HZ)
        else $error("Nonzero hertz word did not beat speed word");

    chk_scaled_limit: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        mag17(FREQ_SCALED_OUT) <= 17'd20000)
        else $error("Applied scaled frequency exceeds full scale");

    chk_scaled_stored: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        is_write(REQ_IN, IDX_FREQ_SCALED) ##1 (REQ_IN.rd && REQ_IN.idx == IDX_FREQ_SCALED &&
        !REQ_IN.wr) |=> RDATA_OUT == $past(REQ_IN.wdata, 2))
        else $error("Scaled word not stored as written");

    chk_pid_negative: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        (pid_process && pid_main_r[15]) |=> PID_MAIN_OUT == 16'h0000)
        else $error("Negative PID word applied under process PID");

    chk_readback_pid: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        (REQ_IN.rd && REQ_IN.idx == IDX_PID_MAIN) |=> RVALID_OUT && RDATA_OUT == $past(pid_main_r))
        else $error("PID word readback differs from stored word");

    chk_commit_cycle: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        (is_write(REQ_IN, IDX_CLK_COMMIT) && REQ_IN.wdata == 16'h0001) ##1
        !is_write(REQ_IN, IDX_CLK_COMMIT) |=> CLOCK_LOAD_OUT && commit_r == 16'h0000)
        else $error("Clock commit did not load and clear");

    chk_fault_read_zero: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        (REQ_IN.rd && REQ_IN.idx == IDX_FAULT_CLEAR) |=> RDATA_OUT == 16'h0000)
        else $error("Alarm reset word read nonzero");

    chk_fault_pulse: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        pulse_reset_trig |=> ALARM_RESET_OUT [*2])
        else $error("Alarm reset word write did not raise reset");

    chk_word_reset_gate: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        (!ALARM_RESET_OUT && !pulse_reset_trig && !link_en_r) |=> !ALARM_RESET_OUT)
        else $error("Operation word reset passed while link disabled");

    chk_pulse_ends: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        (pulse_r == PULSE_ACTIVE && pulse_cnt_r >= 32'(PULSE_CYCLES - 1) &&
         !word_reset_trig && !pulse_reset_trig) |=> !ALARM_RESET_OUT)
        else $error("Alarm reset did not end after its period");

endmodule : dcr_command_bank

// ### tb/dcr_host_model.sv
// Behavioural remote host issuing register requests to the command bank
`timescale 1ns/1ps
module dcr_host_model
    import dcr_pkg::*;
(
    input wire logic clk_in,
    output dcr_req_type req_out
);
    // ==========================================================
    // Bus cycles
    initial req_out = '0;

    // Request held over one rising edge; idle releases it
    task automatic write(input logic [7:0] idx, input logic [15:0] data);
        req_out = '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: data};
        @(posedge clk_in);
        #1;
    endtask : write

    task automatic read(input logic [7:0] idx);
        req_out = '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: 16'h0000};
        @(posedge clk_in);
        #1;
    endtask : read

    task automatic idle(input int n);
        req_out = '0;
        repeat (n) begin
            @(posedge clk_in);
            #1;
        end
    endtask : idle

    // ==========================================================
    // Command sequences
    // Time words first, commit last
    task automatic set_clock(input logic [15:0] ym, input logic [15:0] dh, input logic [15:0] ms);
        write(IDX_CLK_YEAR_MONTH, ym);
        write(IDX_CLK_DAY_HOUR, dh);
        write(IDX_CLK_MIN_SEC, ms);
        write(IDX_CLK_COMMIT, COMMIT_WRITE);
    endtask : set_clock

    task automatic alarm_by_word(input logic [15:0] base);
        write(IDX_RUN_WORD, base | 16'h8000);
        write(IDX_RUN_WORD, base & 16'h7fff);
    endtask : alarm_by_word
endmodule : dcr_host_model

// ### tb/dcr_command_bank_tb.sv
// Self-checking testbench of the drive command register bank
`timescale 1ns/1ps
module dcr_command_bank_tb;
    import dcr_pkg::*;
    // Short reset pulse keeps the run brief
    localparam int PULSE = 8;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [16:0] upper_limit = 17'd20000;
    logic [1:0] pid_mode = 2'd0;
    logic link_sel_ok = 1'b0;
    logic link_term = 1'b0;
    dcr_req_type req;
    // Outputs land on nets driven only by the bank
    wire logic [15:0] rdata;
    wire logic [15:0] f_scaled;
    wire logic [15:0] f_hz;
    wire logic [15:0] speed;
    wire logic [15:0] pid_main;
    wire logic [47:0] ext_pid;
    wire logic [8:0] gp;
    wire logic rvalid;
    wire logic run_fwd;
    wire logic run_rev;
    wire logic link_en;
    wire logic cload;
    wire logic alarm;
    wire dcr_src_type src;
    wire dcr_time_type ctime;
    int n_errors = 0;
    int tests_run = 0;
    int n_load = 0;
    int n_alarm = 0;
    int a0;
    int seed = 32'h7c9743ad;
    logic [15:0] exp_q[$];
    logic [7:0] idx_t[11] = '{8'h01, 8'h05, 8'h06, 8'h0d, 8'h13, 8'h1f, 8'h20, 8'h21, 8'h5a, 8'h5b, 8'h5c};
    logic [15:0] val[11];
    logic [16:0] lim_t[3] = '{17'd30000, 17'd10000, 17'd20000};
    logic [15:0] wr_t[3] = '{16'h61a8, 16'hc568, 16'h8000};
    logic [15:0] ex_t[3] = '{16'h4e20, 16'hd8f0, 16'hb1e0};

    always #5 clk = ~clk;

    dcr_host_model i_dcr_host_model (.clk_in(clk), .req_out(req));

    dcr_command_bank #(.PULSE_CYCLES(PULSE)) i_dcr_command_bank (
        .CLK_IN(clk), .RESETN_IN(resetn), .REQ_IN(req), .FREQ_UPPER_LIMIT_IN(upper_limit),
        .PID_MODE_IN(pid_mode), .LINK_SEL_OK_IN(link_sel_ok), .LINK_ENABLE_TERMINAL_IN(link_term),
        .RDATA_OUT(rdata), .RVALID_OUT(rvalid), .FREQ_SOURCE_OUT(src), .FREQ_SCALED_OUT(f_scaled),
        .FREQ_HZ_OUT(f_hz), .SPEED_RPM_OUT(speed), .PID_MAIN_OUT(pid_main), .EXT_PID_OUT(ext_pid),
        .RUN_FORWARD_OUT(run_fwd), .RUN_REVERSE_OUT(run_rev), .GENERAL_INPUTS_OUT(gp),
        .LINK_ENABLED_OUT(link_en), .CLOCK_TIME_OUT(ctime), .CLOCK_LOAD_OUT(cload), .ALARM_RESET_OUT(alarm)
    );

    // ==========================================================
    // Comparison, scoreboard and verdict
    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic rd_chk(input logic [7:0] idx, input logic [15:0] exp);
        exp_q.push_back(exp);
        i_dcr_host_model.read(idx);
    endtask : rd_chk

    task automatic print_verdict();
        $display("Checks run %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    // Negedge sampling sees registered outputs settled
    always @(negedge clk) begin
        n_load += int'(cload === 1'b1);
        n_alarm += int'(alarm === 1'b1);
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0)
                check("unexpected read", 48'h1, 48'h0);
            else
                check("read data", 48'(rdata), 48'(exp_q.pop_front()));
        end
    end

    initial begin
        #50000;
        n_errors++;
        print_verdict();
    end

    // ==========================================================
    // Scenarios
    initial begin
        repeat (5) @(posedge clk);
        #1;
        resetn = 1'b1;
        check("source at reset", 48'(src), 48'(SRC_NONE));
        rd_chk(IDX_FREQ_HZ, WORD_RESET);
        foreach (idx_t[i]) begin
            val[i] = 16'($random(seed));
            i_dcr_host_model.write(idx_t[i], val[i]);
        end
        foreach (idx_t[i]) rd_chk(idx_t[i], val[i]);
        i_dcr_host_model.idle(2);
        check("hz word", 48'(f_hz), 48'(val[1]));
        check("speed word", 48'(speed), 48'(val[4]));
        check("ext pid", ext_pid, {val[7], val[6], val[5]});
        check("fwd", 48'(run_fwd), 48'(val[2][0]));
        check("rev", 48'(run_rev), 48'(val[2][1]));
        check("inputs", 48'(gp), 48'({val[2][14:13], val[2][8:2]}));
        i_dcr_host_model.write(8'h02, 16'h5a5a);
        rd_chk(8'h02, 16'h0000);
        i_dcr_host_model.write(IDX_FREQ_SCALED, 16'h0000);
        i_dcr_host_model.write(IDX_FREQ_HZ, 16'h1770);
        i_dcr_host_model.idle(2);
        check("hz over speed", 48'(src), 48'(SRC_HZ));
        i_dcr_host_model.write(IDX_FREQ_HZ, 16'h0000);
        i_dcr_host_model.idle(2);
        check("speed when hz zero", 48'(src), 48'(SRC_SPEED));
        i_dcr_host_model.write(IDX_FREQ_SCALED, 16'h2710);
        i_dcr_host_model.idle(2);
        check("scaled first", 48'(src), 48'(SRC_SCALED));
        check("half scale", 48'(f_scaled), 48'h2710);
        for (int i = 0; i < 3; i++) begin
            upper_limit = lim_t[i];
            i_dcr_host_model.write(IDX_FREQ_SCALED, wr_t[i]);
            i_dcr_host_model.idle(2);
            check("limited freq", 48'(f_scaled), 48'(ex_t[i]));
        end
        // Read straight after the write, so the stored-word check sees the pair
        i_dcr_host_model.write(IDX_FREQ_SCALED, 16'h8000);
        rd_chk(IDX_FREQ_SCALED, 16'h8000);
        i_dcr_host_model.write(IDX_PID_MAIN, 16'hfffb);
        for (int m = 0; m < 4; m++) begin
            pid_mode = 2'(m);
            i_dcr_host_model.idle(2);
            check("pid main", 48'(pid_main), 48'((m == 1 || m == 2) ? 16'h0000 : 16'hfffb));
        end
        i_dcr_host_model.set_clock(16'h1234, 16'h0517, 16'h3b2a);
        // Load strobe follows the commit edge by one clock
        check("load early", 48'(cload), 48'h0);
        i_dcr_host_model.idle(1);
        check("clock load", 48'(cload), 48'h1);
        check("clock time", 48'(ctime), 48'h1234_0517_3b2a);
        rd_chk(IDX_CLK_COMMIT, 16'h0000);
        a0 = n_load;
        i_dcr_host_model.write(IDX_CLK_COMMIT, 16'h0000);
        i_dcr_host_model.idle(4);
        check("deactivate", 48'(n_load - a0), 48'h0);
        i_dcr_host_model.write(IDX_FAULT_CLEAR, FAULT_CLEAR_WRITE);
        a0 = n_alarm;
        i_dcr_host_model.idle(1);
        check("alarm start", 48'(alarm), 48'h1);
        i_dcr_host_model.idle(PULSE + 3);
        check("alarm length", 48'(n_alarm - a0), 48'(PULSE));
        rd_chk(IDX_FAULT_CLEAR, 16'h0000);
        link_term = 1'b1;
        i_dcr_host_model.idle(8);
        check("link off", 48'(link_en), 48'h0);
        a0 = n_alarm;
        i_dcr_host_model.alarm_by_word(16'h0000);
        i_dcr_host_model.idle(PULSE + 4);
        check("word reset gated", 48'(n_alarm - a0), 48'h0);
        link_sel_ok = 1'b1;
        i_dcr_host_model.idle(8);
        check("link on", 48'(link_en), 48'h1);
        a0 = n_alarm;
        i_dcr_host_model.alarm_by_word(16'h0000);
        i_dcr_host_model.idle(2);
        check("word reset", 48'(alarm), 48'h1);
        i_dcr_host_model.idle(PULSE + 4);
        check("word reset length", 48'(n_alarm - a0), 48'(PULSE));
        check("reads pending", 48'(exp_q.size()), 48'h0);
        print_verdict();
    end
endmodule : dcr_command_bank_tb
